// ===== design/ttq_pkg.sv
package ttq_pkg;

// Operation
// - Pattern matches only when all labels match.
// - Per-pattern sense bit selects equal or not-equal.
// - Range gives inside result and its complement.
// - Set one: range, not-range, patterns zero-three.
// - Between-set AND or OR joins set results only.
// - Each set reduces by OR or NOR, never both.
// - Reduce each set first, then join sets.
// - NOR of one resource gives its complement.
// - Address label covers trace bits 0 to 23.
// - Data label covers trace bits 32 to 47.
// - Status label covers trace bits 24 to 31.
// - External bits are compared only when enabled; disabled, they are ignored.
// - Care mask ignores don't-care bits in comparison.
// - All don't-care label matches every state.
// - Complete only after trigger and memory filled.
// - Running while untriggered or memory not filled.
// - Reset command restores default qualification setup.

	localparam int ADDR_LO = 0;
	localparam int ADDR_HI = 23;
	localparam int STAT_LO = 24;
	localparam int STAT_HI = 31;
	localparam int DATA_LO = 32;
	localparam int DATA_HI = 47;
	localparam int XB_LO   = 48;
	localparam int XB_HI   = 63;
	localparam int TW      = 64;
	localparam int NPAT    = 8;
	localparam int CNT_W   = 16;
	localparam int FIFO_W  = 48;
	localparam int FIFO_D  = 16;

	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_EXPR    = 8'h04;
	localparam logic [7:0] OFF_RSEL    = 8'h08;
	localparam logic [7:0] OFF_RLO     = 8'h0C;
	localparam logic [7:0] OFF_RHI     = 8'h10;
	localparam logic [7:0] OFF_STAT    = 8'h14;
	localparam logic [7:0] OFF_FLO     = 8'h18;
	localparam logic [7:0] OFF_FHI     = 8'h1C;
	localparam logic [7:0] OFF_SENSE   = 8'h20;
	localparam logic [7:0] OFF_PAT     = 8'h40;
	localparam logic [7:0] OFF_PAT_END = 8'hBC;

	localparam int CTRL_BEGIN = 0;
	localparam int CTRL_HALT  = 1;
	localparam int CTRL_RESET = 2;
	localparam int CTRL_XEN   = 3;

	localparam int EX_SEL1 = 0;
	localparam int EX_NOR1 = 6;
	localparam int EX_SEL2 = 8;
	localparam int EX_NOR2 = 13;
	localparam int EX_OR   = 16;

	localparam logic [31:0] EXPR_RST  = 32'h0000_2040;
	localparam logic [31:0] RLO_RST   = 32'h0000_0000;
	localparam logic [31:0] RHI_RST   = 32'h0000_0000;
	localparam logic [7:0]  SENSE_RST = 8'h00;

	typedef enum logic [1:0] {
		LBL_ADDR = 2'b00,
		LBL_DATA = 2'b01,
		LBL_STAT = 2'b10,
		LBL_XB   = 2'b11
	} ttq_label_t;

endpackage

// ===== design/ttq_fifo.sv
module ttq_fifo #(
	parameter int W = 48,
	parameter int D = 16
)(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   n_q;
	logic          push;
	logic          pop;

	assign in_ready  = n_q != (AW+1)'(D);
	assign out_valid = n_q != '0;
	assign out_data  = mem[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_q] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
			n_q  <= '0;
		end
		else if (clr)
		begin
			wp_q <= '0;
			rp_q <= '0;
			n_q  <= '0;
		end
		else
		begin
			if (push)
				wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
			if (pop)
				rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
			n_q <= n_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ===== design/ttq_trace_qualifier.sv
module ttq_trace_qualifier
	import ttq_pkg::*;
#(
	parameter int TDEPTH = 1024,
	parameter int FDEPTH = FIFO_D
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cap_valid,
	output logic             cap_ready,
	input  wire logic [23:0] cap_addr,
	input  wire logic [7:0]  cap_stat,
	input  wire logic [15:0] cap_data,
	input  wire logic [15:0] cap_xbits,
	input  wire logic        arm_in,
	output logic             trace_running,
	output logic             trace_complete
);
	logic              run_q;
	logic              trig_q;
	logic              xen_q;
	logic [31:0]       expr_q;
	logic [31:0]       rlo_q;
	logic [31:0]       rhi_q;
	ttq_label_t        rsel_q;
	logic [NPAT-1:0]   sense_q;
	logic [TW-1:0]     pv_q [NPAT];
	logic [TW-1:0]     pc_q [NPAT];
	logic [CNT_W-1:0]  cnt_q;
	logic [31:0]       prdata_q;
	logic              p_vld_q;
	logic              p_qual_q;
	logic [FIFO_W-1:0] p_st_q;

	logic              wr_en;
	logic              rd_setup;
	logic              pat_hit;
	logic              mapped;
	logic              ctrl_wr;
	logic              cmd_begin;
	logic              cmd_halt;
	logic              cmd_rst;
	logic [3:0]        pw;
	logic [2:0]        pidx;
	logic [31:0]       rd_c;
	logic [TW-1:0]     st_c;
	logic [TW-1:0]     care_gate;
	logic [NPAT-1:0]   pm;
	logic [31:0]       fld;
	logic              in_rng;
	logic [5:0]        s1;
	logic [4:0]        s2;
	logic              r1;
	logic              r2;
	logic              qual_c;
	logic              done_c;
	logic              need_push;
	logic              adv;
	logic              f_in_ready;
	logic              f_out_valid;
	logic              pop;
	logic [FIFO_W-1:0] f_out_data;

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, error on unmapped words.

	assign wr_en     = psel && penable && pwrite;
	assign rd_setup  = psel && !penable && !pwrite;
	assign pat_hit   = paddr >= OFF_PAT && paddr <= OFF_PAT_END;
	assign mapped    = paddr[1:0] == 2'b00 && (pat_hit || paddr <= OFF_SENSE);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign prdata    = prdata_q;
	assign ctrl_wr   = wr_en && paddr == OFF_CTRL;
	assign cmd_begin = ctrl_wr && pwdata[CTRL_BEGIN];
	assign cmd_halt  = ctrl_wr && pwdata[CTRL_HALT];
	assign cmd_rst   = ctrl_wr && pwdata[CTRL_RESET];
	assign pw        = paddr[7:4] - 4'h4;
	assign pidx      = pw[2:0];
	assign pop       = psel && penable && !pwrite && paddr == OFF_FHI && f_out_valid;

	always_comb
	begin
		rd_c = 32'h0000_0000;
		if (pat_hit && paddr[1:0] == 2'b00)
		begin
			unique case (paddr[3:2])
				2'b00: rd_c = pv_q[pidx][31:0];
				2'b01: rd_c = pv_q[pidx][63:32];
				2'b10: rd_c = pc_q[pidx][31:0];
				2'b11: rd_c = pc_q[pidx][63:32];
			endcase
		end
		else
		begin
			case (paddr)
				OFF_CTRL:  rd_c = {28'h0000000, xen_q, 3'h0};
				OFF_EXPR:  rd_c = expr_q;
				OFF_RSEL:  rd_c = {30'h0, rsel_q};
				OFF_RLO:   rd_c = rlo_q;
				OFF_RHI:   rd_c = rhi_q;
				OFF_STAT:  rd_c = {cnt_q, 12'h000, f_out_valid, done_c, trig_q, trace_running};
				OFF_FLO:   rd_c = f_out_data[31:0];
				OFF_FHI:   rd_c = {16'h0000, f_out_data[47:32]};
				OFF_SENSE: rd_c = {24'h000000, sense_q};
				default:   rd_c = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (rd_setup)
			prdata_q <= rd_c;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Qualification setup registers.

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			expr_q  <= EXPR_RST;
			rsel_q  <= LBL_ADDR;
			rlo_q   <= RLO_RST;
			rhi_q   <= RHI_RST;
			sense_q <= SENSE_RST;
			xen_q   <= 1'b0;
		end
		else if (cmd_rst)
		begin
			expr_q  <= EXPR_RST;
			rsel_q  <= LBL_ADDR;
			rlo_q   <= RLO_RST;
			rhi_q   <= RHI_RST;
			sense_q <= SENSE_RST;
			xen_q   <= 1'b0;
		end
		else if (wr_en)
		begin
			case (paddr)
				OFF_CTRL:  xen_q <= pwdata[CTRL_XEN];
				OFF_EXPR:  expr_q <= pwdata;
				OFF_RSEL:  rsel_q <= ttq_label_t'(pwdata[1:0]);
				OFF_RLO:   rlo_q <= pwdata;
				OFF_RHI:   rhi_q <= pwdata;
				OFF_SENSE: sense_q <= pwdata[7:0];
				default:   ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NPAT; i++)
			begin
				pv_q[i] <= '0;
				pc_q[i] <= '0;
			end
		end
		else if (cmd_rst)
		begin
			for (int i = 0; i < NPAT; i++)
			begin
				pv_q[i] <= '0;
				pc_q[i] <= '0;
			end
		end
		else if (wr_en && pat_hit && paddr[1:0] == 2'b00)
		begin
			unique case (paddr[3:2])
				2'b00: pv_q[pidx][31:0] <= pwdata;
				2'b01: pv_q[pidx][63:32] <= pwdata;
				2'b10: pc_q[pidx][31:0] <= pwdata;
				2'b11: pc_q[pidx][63:32] <= pwdata;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pattern, range and set evaluation on the incoming bus state.

	assign st_c      = {cap_xbits, cap_data, cap_stat, cap_addr};
	assign care_gate = {{(XB_HI - XB_LO + 1){xen_q}}, {XB_LO{1'b1}}};

	for (genvar g = 0; g < NPAT; g++)
	begin : g_pat
		// A clear care bit is a don't-care position, so an all-clear label matches anything.
		assign pm[g] = (~|((st_c ^ pv_q[g]) & pc_q[g] & care_gate)) ^ sense_q[g];
	end

	always_comb
	begin
		unique case (rsel_q)
			LBL_ADDR: fld = {8'h00, st_c[ADDR_HI:ADDR_LO]};
			LBL_DATA: fld = {16'h0000, st_c[DATA_HI:DATA_LO]};
			LBL_STAT: fld = {24'h000000, st_c[STAT_HI:STAT_LO]};
			LBL_XB:   fld = xen_q ? {16'h0000, st_c[XB_HI:XB_LO]} : 32'h0000_0000;
		endcase
	end

	assign in_rng = fld >= rlo_q && fld <= rhi_q;
	assign s1     = {pm[3:0], ~in_rng, in_rng};
	assign s2     = {arm_in, pm[7:4]};
	// An empty selection reduces to zero under OR and to one under NOR.
	assign r1     = (|(s1 & expr_q[EX_SEL1 +: 6])) ^ expr_q[EX_NOR1];
	assign r2     = (|(s2 & expr_q[EX_SEL2 +: 5])) ^ expr_q[EX_NOR2];
	assign qual_c = expr_q[EX_OR] ? (r1 || r2) : (r1 && r2);

	////////////////////////////////////////////////////////////////////////////////
	// Capture stage, trigger detection and storage into the trace buffer.

	assign done_c         = trig_q && cnt_q == CNT_W'(TDEPTH);
	assign need_push      = run_q && !done_c && (trig_q || p_qual_q);
	assign adv            = !need_push || f_in_ready;
	assign cap_ready      = !p_vld_q || adv;
	assign trace_running  = run_q && !done_c;
	assign trace_complete = done_c;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p_vld_q  <= 1'b0;
			p_qual_q <= 1'b0;
			p_st_q   <= '0;
		end
		else if (cap_ready)
		begin
			p_vld_q <= cap_valid;
			if (cap_valid)
			begin
				p_qual_q <= qual_c;
				p_st_q   <= st_c[FIFO_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_q  <= 1'b0;
			trig_q <= 1'b0;
			cnt_q  <= '0;
		end
		else if (cmd_halt || cmd_rst)
			run_q <= 1'b0;
		else if (cmd_begin)
		begin
			run_q  <= 1'b1;
			trig_q <= 1'b0;
			cnt_q  <= '0;
		end
		else if (p_vld_q && adv && run_q && !done_c)
		begin
			if (p_qual_q)
				trig_q <= 1'b1;
			if (need_push)
				cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	ttq_fifo #(
		.W (FIFO_W),
		.D (FDEPTH)
	) u_fifo (
		.clk       (pclk),
		.rst_n     (presetn),
		.clr       (cmd_begin),
		.in_valid  (p_vld_q && need_push),
		.in_ready  (f_in_ready),
		.in_data   (p_st_q),
		.out_valid (f_out_valid),
		.out_ready (pop),
		.out_data  (f_out_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_begin;
		ctrl_wr && pwdata[CTRL_BEGIN] && !pwdata[CTRL_HALT] && !pwdata[CTRL_RESET];
	endsequence
	sequence s_trig_seen;
		p_vld_q && adv && run_q && !trig_q && p_qual_q && !ctrl_wr;
	endsequence

	property p_begin;
		s_begin |=> run_q && !trig_q && cnt_q == '0 && trace_running;
	endproperty
	a_begin: assert property (p_begin) else $error("begin did not restart the trace");

	property p_trig;
		s_trig_seen |=> trig_q;
	endproperty
	a_trig: assert property (p_trig) else $error("qualified state did not trigger");

	property p_done;
		trace_complete |-> trig_q && cnt_q == CNT_W'(TDEPTH) && !trace_running;
	endproperty
	a_done: assert property (p_done) else $error("complete without trigger and full memory");

	property p_run;
		run_q && !trig_q |-> trace_running && !trace_complete;
	endproperty
	a_run: assert property (p_run) else $error("untriggered trace not running");

	property p_dontcare;
		pc_q[0] == '0 && !sense_q[0] |-> pm[0];
	endproperty
	a_dontcare: assert property (p_dontcare) else $error("all don't-care pattern missed");

	property p_sense;
		pc_q[1] == '0 && sense_q[1] |-> !pm[1];
	endproperty
	a_sense: assert property (p_sense) else $error("not-equal sense did not invert");

	property p_and;
		pc_q[5][DATA_HI:0] == '1 && st_c[DATA_HI:0] != pv_q[5][DATA_HI:0] && !sense_q[5] |-> !pm[5];
	endproperty
	a_and: assert property (p_and) else $error("pattern matched with a label differing");

	property p_xb;
		!xen_q && pc_q[3][DATA_HI:0] == '0 && !sense_q[3] |-> pm[3];
	endproperty
	a_xb: assert property (p_xb) else $error("external bits used while disabled");

	property p_rng;
		fld > rhi_q || fld < rlo_q |-> !in_rng;
	endproperty
	a_rng: assert property (p_rng) else $error("out of range value reported inside");

	property p_nor;
		expr_q[EX_SEL1 +: 6] == 6'h04 && expr_q[EX_NOR1] |-> r1 == !pm[0];
	endproperty
	a_nor: assert property (p_nor) else $error("single NOR is not a complement");

	property p_inter;
		!expr_q[EX_OR] && !r2 |-> !qual_c;
	endproperty
	a_inter: assert property (p_inter) else $error("AND between sets passed a false set");

	property p_cap;
		cap_valid && cap_ready |=> p_vld_q && p_qual_q == $past(qual_c);
	endproperty
	a_cap: assert property (p_cap) else $error("captured state lost its qualifier");

	property p_rst;
		cmd_rst |=> expr_q == EXPR_RST && sense_q == SENSE_RST && !run_q && !xen_q;
	endproperty
	a_rst: assert property (p_rst) else $error("reset command left setup changed");

	property p_stall;
		p_vld_q && need_push && !f_in_ready && !ctrl_wr && !pop |=> p_vld_q && $stable(p_st_q) && !cap_ready;
	endproperty
	a_stall: assert property (p_stall) else $error("stored state dropped under back-pressure");
endmodule

// ===== testbench/ttq_bus_model.sv
module ttq_bus_model (
	input  wire logic        clk,
	input  wire logic        cap_ready,
	output logic             cap_valid,
	output logic [23:0]      cap_addr,
	output logic [7:0]       cap_stat,
	output logic [15:0]      cap_data,
	output logic [15:0]      cap_xbits,
	output logic             arm
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		cap_valid = 1'b0;
		cap_addr  = 24'h0;
		cap_stat  = 8'h0;
		cap_data  = 16'h0;
		cap_xbits = 16'h0;
		arm       = 1'b0;
	end

	// One bus state is offered only when the bench commands it, so nothing is captured before the processor runs.
	task automatic send(input logic [23:0] a, input logic [7:0] s, input logic [15:0] d, input logic [15:0] x,
		input logic am);
		@(posedge clk);
		cap_valid <= 1'b1;
		cap_addr  <= a;
		cap_stat  <= s;
		cap_data  <= d;
		cap_xbits <= x;
		arm       <= am;
		do @(posedge clk); while (cap_ready !== 1'b1);
		// Released lines other than arm show the inverse so a stale value can never pass for a fresh one; arm keeps its value.
		cap_valid <= 1'b0;
		cap_addr  <= ~a;
		cap_stat  <= ~s;
		cap_data  <= ~d;
		cap_xbits <= ~x;
	endtask
endmodule

// ===== testbench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TD = 20;
	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_valid;
	logic        cap_ready;
	logic [23:0] cap_addr;
	logic [7:0]  cap_stat;
	logic [15:0] cap_data;
	logic [15:0] cap_xbits;
	logic        arm;
	logic        trace_running;
	logic        trace_complete;
	int          n_fail      = 0;
	int          comparisons = 0;

	always #25 pclk = ~pclk;

	ttq_trace_qualifier #(.TDEPTH(TD), .FDEPTH(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cap_valid(cap_valid), .cap_ready(cap_ready), .cap_addr(cap_addr),
		.cap_stat(cap_stat), .cap_data(cap_data), .cap_xbits(cap_xbits), .arm_in(arm),
		.trace_running(trace_running), .trace_complete(trace_complete));

	ttq_bus_model bus_u (.clk(pclk), .cap_ready(cap_ready), .cap_valid(cap_valid), .cap_addr(cap_addr),
		.cap_stat(cap_stat), .cap_data(cap_data), .cap_xbits(cap_xbits), .arm(arm));

	////////////////////////////////////////////////////////////////////////////////

	task automatic wrap_up();
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0, d, e);
	endtask

	////////////////////////////////////////////////////////////////////////////////

	task automatic t_reset_values();
		logic [31:0] d;
		logic        e;
		rd(ttq_pkg::OFF_EXPR, d);
		chk("expr", ttq_pkg::EXPR_RST, d);
		rd(ttq_pkg::OFF_RHI, d);
		chk("range hi", ttq_pkg::RHI_RST, d);
		rd(ttq_pkg::OFF_STAT, d);
		chk("status", 32'h0, d);
		apb(1'b0, 8'h24, 32'h0, d, e);
		chk("unmapped", 32'h1, {d[30:0], e});
		chk("ready", 32'h1, {31'h0, pready});
	endtask

	task automatic t_setup();
		wr(8'h40, 32'h0000_0500);
		wr(8'h44, 32'h0000_1234);
		wr(8'h48, 32'h00FF_FFFF);
		wr(8'h4C, 32'h0000_FFFF);
		wr(8'h54, 32'h00AB_0000);
		wr(8'h5C, 32'hFFFF_0000);
		wr(8'h80, 32'h0500_0000);
		wr(8'h88, 32'h0F00_0000);
		// Pattern d compares only external bits and pattern f every internal bit, for the design's own checks.
		wr(8'h7C, 32'hFFFF_0000);
		wr(8'h98, 32'hFFFF_FFFF);
		wr(8'h9C, 32'h0000_FFFF);
		wr(ttq_pkg::OFF_RSEL, 32'h0);
		wr(ttq_pkg::OFF_RLO, 32'h100);
		wr(ttq_pkg::OFF_RHI, 32'h1FF);
	endtask

	// One state is offered after Begin and the triggered flag shows whether it qualified.
	task automatic run_case(input logic [31:0] ex, input logic [7:0] se, input logic xe, input logic [23:0] a,
		input logic [7:0] s, input logic [15:0] d, input logic [15:0] x, input logic am, input logic exp);
		logic [31:0] st;
		wr(ttq_pkg::OFF_EXPR, ex);
		wr(ttq_pkg::OFF_SENSE, {24'h0, se});
		wr(ttq_pkg::OFF_CTRL, {28'h0, xe, 3'b001});
		bus_u.send(a, s, d, x, am);
		repeat (3) @(posedge pclk);
		rd(ttq_pkg::OFF_STAT, st);
		chk("triggered", {31'h0, exp}, {31'h0, st[1]});
		wr(ttq_pkg::OFF_CTRL, 32'h2);
	endtask

	task automatic t_qualifier();
		run_case(32'h2004, 8'h00, 1'b0, 24'h000500, 8'h00, 16'h1234, 16'h0, 1'b0, 1'b1);
		run_case(32'h2004, 8'h00, 1'b0, 24'h000500, 8'h00, 16'h1235, 16'h0, 1'b0, 1'b0);
		run_case(32'h2004, 8'h00, 1'b0, 24'h000501, 8'h00, 16'h1234, 16'h0, 1'b0, 1'b0);
		run_case(32'h2004, 8'h01, 1'b0, 24'h000500, 8'h00, 16'h1235, 16'h0, 1'b0, 1'b1);
		run_case(32'h2004, 8'h01, 1'b0, 24'h000500, 8'h00, 16'h1234, 16'h0, 1'b0, 1'b0);
		run_case(32'h2001, 8'h00, 1'b0, 24'h0001FF, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b1);
		run_case(32'h2001, 8'h00, 1'b0, 24'h000200, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b0);
		run_case(32'h2002, 8'h00, 1'b0, 24'h000200, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b1);
		run_case(32'h2044, 8'h00, 1'b0, 24'h000500, 8'h00, 16'h1234, 16'h0, 1'b0, 1'b0);
		run_case(32'h2044, 8'h00, 1'b0, 24'h000500, 8'h00, 16'h1235, 16'h0, 1'b0, 1'b1);
		run_case(32'h0140, 8'h00, 1'b0, 24'h000000, 8'hF5, 16'h0000, 16'h0, 1'b0, 1'b1);
		run_case(32'h0140, 8'h00, 1'b0, 24'h000000, 8'h06, 16'h0000, 16'h0, 1'b0, 1'b0);
		run_case(32'h1040, 8'h00, 1'b0, 24'h000000, 8'h00, 16'h0000, 16'h0, 1'b1, 1'b1);
		run_case(32'h1040, 8'h00, 1'b0, 24'h000000, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b0);
		run_case(32'h10104, 8'h00, 1'b0, 24'h000000, 8'hF5, 16'h0000, 16'h0, 1'b0, 1'b1);
		run_case(32'h0104, 8'h00, 1'b0, 24'h000000, 8'hF5, 16'h0000, 16'h0, 1'b0, 1'b0);
		run_case(32'h2005, 8'h00, 1'b0, 24'h000150, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b1);
		run_case(32'h2008, 8'h00, 1'b0, 24'h000000, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b1);
		run_case(32'h2008, 8'h00, 1'b1, 24'h000000, 8'h00, 16'h0000, 16'h0, 1'b0, 1'b0);
		run_case(32'h2008, 8'h00, 1'b1, 24'h000000, 8'h00, 16'h0000, 16'h00AB, 1'b0, 1'b1);
		run_case(32'h2010, 8'h00, 1'b0, 24'h123456, 8'h77, 16'h5A5A, 16'h0, 1'b0, 1'b1);
	endtask

	task automatic t_reset_cmd();
		logic [31:0] d;
		wr(ttq_pkg::OFF_CTRL, 32'h4);
		rd(ttq_pkg::OFF_EXPR, d);
		chk("expr", ttq_pkg::EXPR_RST, d);
		rd(ttq_pkg::OFF_RLO, d);
		chk("range lo", ttq_pkg::RLO_RST, d);
		rd(8'h40, d);
		chk("pattern", 32'h0, d);
	endtask

	// The FIFO fills and stalls capture before the trace depth is reached, then draining lets the trace finish.
	task automatic t_fill_drain();
		logic [31:0] d;
		wr(ttq_pkg::OFF_CTRL, 32'h1);
		fork
			for (int j = 0; j < TD; j++)
				bus_u.send(24'h001000 + 24'(j), 8'(j), 16'hA000 + 16'(j), 16'h0, 1'b0);
		join_none
		repeat (40) @(posedge pclk);
		chk("capture ready", 32'h0, {31'h0, cap_ready});
		rd(ttq_pkg::OFF_STAT, d);
		chk("status", 32'h0010_000B, d);
		chk("running pin", 32'h1, {31'h0, trace_running});
		for (int i = 0; i < TD; i++)
		begin
			rd(ttq_pkg::OFF_FLO, d);
			chk("word low", {8'(i), 24'h001000 + 24'(i)}, d);
			rd(ttq_pkg::OFF_FHI, d);
			chk("word high", {16'h0, 16'hA000 + 16'(i)}, d);
		end
		repeat (3) @(posedge pclk);
		rd(ttq_pkg::OFF_STAT, d);
		chk("status", 32'h0014_0006, d);
		chk("complete pin", 32'h1, {31'h0, trace_complete});
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		wrap_up();
	end

	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_setup();
		t_qualifier();
		t_reset_cmd();
		t_fill_drain();
		wrap_up();
	end
endmodule
